//--- sbac_analyzer_model.sv
// sbac_analyzer_model: analyzer and packet writer stand-in
module sbac_analyzer_model (
	input wire logic core_clk_i,
	input wire logic wr_gnt_i,
	input wire logic [sbac_pkg::CW-1:0] wr_word_i,
	output logic frm_vld_o,
	output sbac_pkg::sbac_frame_t frm_o,
	output logic wr_req_o,
	output sbac_pkg::sbac_word_req_t wr_o,
	output logic rel_vld_o,
	output sbac_pkg::sbac_word_req_t rel_o,
	output logic [sbac_pkg::CW-1:0] rel_word_o
);
	timeunit 1ns;
	timeprecision 100ps;
	sbac_pkg::sbac_word_req_t held_q[$];
	logic [sbac_pkg::CW-1:0] word_q[$];
	// ==========================================================
	// idle values at time zero
	initial begin
		frm_vld_o = 1'b0;
		frm_o = '0;
		wr_req_o = 1'b0;
		wr_o = '0;
		rel_vld_o = 1'b0;
		rel_o = '0;
		rel_word_o = '0;
	end
	// ==========================================================
	// result fields, boundary priority values included
	function automatic sbac_pkg::sbac_frame_t mk(input logic [6:0] p,
		input logic dm, input logic [2:0] oam);
		sbac_pkg::sbac_frame_t f;
		f = '0;
		f.port = p;
		f.res.dest_set = {69'h0, 1'b1} << p;
		f.res.cpu_queue_mask = 8'h5A;
		f.res.mirror_probe = 2'h2;
		f.res.learn_all = 1'b1;
		f.res.drop_mode = dm;
		f.res.drop_precedence = 3'h7;
		f.res.qos = 3'h5;
		f.res.pcp = 3'h0;
		f.res.class_of_service_id = 3'h6;
		f.res.tc = 3'h1;
		f.res.super_priority_flag = 1'b1;
		f.res.service_queue_group = 8'hC3;
		f.res.oam_type = oam;
		return f;
	endfunction
	// ==========================================================
	// frame start; the bus carries junk once released
	task automatic send(input sbac_pkg::sbac_frame_t f);
		@(posedge core_clk_i);
		frm_vld_o <= 1'b1;
		frm_o <= f;
		@(posedge core_clk_i);
		frm_vld_o <= 1'b0;
		frm_o <= ~f;
	endtask
	// word request held until granted, bounded retries
	task automatic alloc(input logic [6:0] p, input logic [2:0] pr,
		output logic ok, output logic [sbac_pkg::CW-1:0] w);
		ok = 1'b0;
		w = '0;
		@(posedge core_clk_i);
		wr_req_o <= 1'b1;
		wr_o <= {p, pr};
		for (int i = 0; i < 4 && ok !== 1'b1; i++) begin
			#1;
			ok = wr_gnt_i;
			@(posedge core_clk_i);
		end
		wr_req_o <= 1'b0;
		wr_o <= ~{p, pr};
		#1;
		if (ok === 1'b1) begin
			w = wr_word_i;
			held_q.push_back({p, pr});
			word_q.push_back(w);
		end
	endtask
	// returns the newest word, charged as it was taken
	task automatic put_back();
		@(posedge core_clk_i);
		rel_vld_o <= 1'b1;
		rel_o <= held_q.pop_back();
		rel_word_o <= word_q.pop_back();
		@(posedge core_clk_i);
		rel_vld_o <= 1'b0;
		rel_o <= ~rel_o;
		rel_word_o <= ~rel_word_o;
	endtask
endmodule // sbac_analyzer_model

//--- sbac_mmgr.sv
// sbac_mmgr: free-word stack that hands out packet memory words
module sbac_mmgr #(
	parameter int NUM_WORDS = sbac_pkg::NUM_WORDS,
	parameter int CW = sbac_pkg::CW
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic alloc_i,
	input wire logic rel_i,
	input wire logic [CW-1:0] rel_word_i,
	output logic avail_o,
	output logic [CW-1:0] word_o,
	output logic [CW-1:0] free_cnt_o
);
	if (NUM_WORDS < 2 || NUM_WORDS >= 2 ** CW) begin : g_chk
		$error("sbac_mmgr: word count does not fit counter");
	end

	typedef struct packed {
		logic [NUM_WORDS-1:0][CW-1:0] stk;
		logic [CW-1:0] cnt;
		logic init;
	} sbac_mm_st_t;

	localparam logic [CW-1:0] LAST = CW'(NUM_WORDS - 1);
	localparam logic [CW-1:0] FULL = CW'(NUM_WORDS);

	sbac_mm_st_t r;
	sbac_mm_st_t n;
	logic [CW-1:0] top;

	// ==========================================================
	// outputs: free count reads zero until the stack is filled
	assign top = r.cnt - 1'b1;
	assign avail_o = !r.init && (r.cnt != '0);
	assign word_o = avail_o ? r.stk[top] : '0;
	assign free_cnt_o = r.init ? '0 : r.cnt;

	// ==========================================================
	// fill one word per cycle after reset; a flop array cannot be
	// preloaded by an async reset without a huge constant
	always_comb begin
		n = r;
		if (r.init) begin
			n.stk[r.cnt] = r.cnt;
			n.cnt = r.cnt + 1'b1;
			n.init = (r.cnt != LAST);
		end else if (alloc_i && avail_o && rel_i) begin
			n.stk[top] = rel_word_i; // swap top, count unchanged
		end else if (alloc_i && avail_o) begin
			n.cnt = top;
		end else if (rel_i && r.cnt != FULL) begin
			n.stk[r.cnt] = rel_word_i;
			n.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
			r.init <= 1'b1;
		end else begin
			r <= n;
		end
	end
endmodule // sbac_mmgr

//--- sbac_pkg.sv
// sbac_pkg: constants, register map and carriers of buffer admission control
package sbac_pkg;
	// ==========================================================
	// memory and port geometry
	localparam int NUM_WORDS = 22795;
	localparam int WORD_BYTES = 184;
	localparam int NUM_PORTS = 70;
	localparam int NUM_PRIO = 8;
	localparam int CW = 15;
	localparam int PORT_W = 7;
	localparam int AW = 11;
	// ==========================================================
	// register map: global flag bit, else {port, sub}
	localparam int GLB_BIT = 10;
	localparam int PORT_LSB = 2;
	localparam logic [1:0] SUB_TAIL = 2'h0;
	localparam logic [1:0] SUB_PAUSE = 2'h1;
	localparam logic [1:0] SUB_SWITCH = 2'h2;
	localparam logic [1:0] SUB_PFC = 2'h3;
	localparam logic [10:0] A_TOT_TAIL = 11'h400;
	localparam logic [10:0] A_TOT_PAUSE = 11'h401;
	localparam logic [10:0] A_VIEW_SEL = 11'h402;
	localparam logic [10:0] A_PORT_USE = 11'h403;
	localparam logic [10:0] A_FREE_CNT = 11'h404;
	localparam logic [10:0] A_OAM_MASK = 11'h405;
	localparam logic [10:0] A_OAM_CNT = 11'h406;
	localparam logic [10:0] A_PRIO_BASE = 11'h408;
	// ==========================================================
	// field positions and reset values
	localparam int PS_START_LSB = 0;
	localparam int PS_STOP_LSB = 16;
	localparam int SW_DROP_BIT = 0;
	localparam int SW_FC_BIT = 1;
	localparam logic [14:0] RST_LIM = 15'h7FFF;
	localparam logic [14:0] RST_STOP = 15'h0000;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [NUM_PORTS-1:0] dest_set;
		logic [7:0] cpu_queue_mask;
		logic [1:0] mirror_probe;
		logic learn_all;
		logic drop_mode;
		logic [2:0] drop_precedence;
		logic [2:0] qos;
		logic [2:0] pcp;
		logic [2:0] class_of_service_id;
		logic [2:0] tc;
		logic super_priority_flag;
		logic [7:0] service_queue_group;
		logic [2:0] oam_type;
	} sbac_result_t;
	typedef struct packed {
		logic [PORT_W-1:0] port;
		sbac_result_t res;
	} sbac_frame_t;
	typedef struct packed {
		logic [PORT_W-1:0] port;
		logic [2:0] prio;
	} sbac_word_req_t;
endpackage

//--- sbac_top.sv
// sbac_top: ingress buffer admission control of the shared queue system
// Functional notes
// - a frame marked drop-mode may be discarded despite port flow control.
// - analyzer gives OAM type; a counter counts only selected OAM types.
// - shared packet memory holds 22,795 words of 184 bytes.
// - memory manager picks the free words each stored frame uses.
// - thresholds trigger pause on flow-controlled ports and discard frames.
// - discarded frames are dropped whole, ignoring destinations.
// - pause and discard need both port and total thresholds reached.
// - pause from port use or per-priority use, separately enabled.
// - per-port maximum use; exceeding it allows tail dropping.
// - one global total use must be exceeded before tail dropping.
// - per-port start and stop thresholds for port flow control.
// - one global total use must be reached before flow control.
// - per-port setting selects drop mode instead of flow control.
// - software selects a port and reads its memory use.
// - selected port's memory use is also readable per priority.
// - number of free packet memory words is readable.
// - drop-mode ports send no congestion signalling.
// - priority flow control reports which classes are congested.
module sbac_top #(
	parameter int NUM_PORTS = sbac_pkg::NUM_PORTS,
	parameter int NUM_WORDS = sbac_pkg::NUM_WORDS
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [sbac_pkg::AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	input wire logic frm_vld_i,
	input wire sbac_pkg::sbac_frame_t frm_i,
	output logic dec_vld_o,
	output logic dec_drop_o,
	output sbac_pkg::sbac_frame_t fwd_o,
	input wire logic wr_req_i,
	input wire sbac_pkg::sbac_word_req_t wr_i,
	output logic wr_gnt_o,
	output logic wr_word_vld_o,
	output logic [sbac_pkg::CW-1:0] wr_word_o,
	input wire logic rel_vld_i,
	input wire sbac_pkg::sbac_word_req_t rel_i,
	input wire logic [sbac_pkg::CW-1:0] rel_word_i,
	output logic [NUM_PORTS-1:0] pause_o,
	output logic [NUM_PORTS-1:0][7:0] pfc_o
);
	localparam int CW = sbac_pkg::CW;
	localparam int PW = sbac_pkg::PORT_W;

	if (NUM_PORTS < 1 || NUM_PORTS > 2 ** PW ||
		NUM_WORDS >= 2 ** CW) begin : g_chk
		$error("sbac_top: port or word count out of range");
	end

	typedef struct packed {
		logic [NUM_PORTS-1:0][CW-1:0] tail_lim;
		logic [NUM_PORTS-1:0][CW-1:0] p_start;
		logic [NUM_PORTS-1:0][CW-1:0] p_stop;
		logic [NUM_PORTS-1:0] drop_md;
		logic [NUM_PORTS-1:0] fc_en;
		logic [NUM_PORTS-1:0][7:0] pfc_en;
		logic [CW-1:0] tot_tail;
		logic [CW-1:0] tot_pause;
		logic [PW-1:0] view_sel;
		logic [7:0] oam_mask;
		logic [31:0] oam_cnt;
		logic [NUM_PORTS-1:0][CW-1:0] puse;
		logic [NUM_PORTS-1:0][7:0][CW-1:0] quse;
		logic [NUM_PORTS-1:0] fc_on;
		logic [NUM_PORTS-1:0][7:0] pfc_on;
		logic [NUM_PORTS-1:0] discard;
		logic dec_vld;
		logic dec_drop;
		sbac_pkg::sbac_frame_t fwd;
		logic wvld;
		logic [CW-1:0] wword;
		logic [31:0] rdata;
	} sbac_st_t;

	sbac_st_t r;
	sbac_st_t n;
	logic mm_avail;
	logic [CW-1:0] mm_word;
	logic [CW-1:0] free_cnt;
	logic [CW-1:0] used;
	logic tot_fc;
	logic fp_ok;
	logic drop_frame;
	logic tail_hit;
	logic early_hit;
	logic [PW-1:0] rp;

	// ==========================================================
	// shared memory word manager
	sbac_mmgr #(
		.NUM_WORDS(NUM_WORDS),
		.CW(CW)
	) u_mmgr (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.alloc_i(wr_gnt_o),
		.rel_i(rel_vld_i),
		.rel_word_i(rel_word_i),
		.avail_o(mm_avail),
		.word_o(mm_word),
		.free_cnt_o(free_cnt)
	);

	// ==========================================================
	// admission terms; words of a discarded frame are never granted
	assign used = CW'(NUM_WORDS) - free_cnt;
	assign tot_fc = used >= r.tot_pause;
	assign fp_ok = frm_i.port < NUM_PORTS;
	assign drop_frame = fp_ok && (r.drop_md[frm_i.port] ||
		frm_i.res.drop_mode);
	assign tail_hit = fp_ok && r.puse[frm_i.port] > r.tail_lim[frm_i.port]
		&& used > r.tot_tail;
	// drop-mode frames get no pause, so they are cut at pause start
	assign early_hit = drop_frame &&
		r.puse[frm_i.port] >= r.p_start[frm_i.port] && tot_fc;
	assign wr_gnt_o = wr_req_i && mm_avail && wr_i.port < NUM_PORTS &&
		!r.discard[wr_i.port];
	assign rp = reg_addr_i[sbac_pkg::PORT_LSB +: PW];

	// ==========================================================
	// outputs, all from flops except the grant
	assign reg_rdata_o = r.rdata;
	assign dec_vld_o = r.dec_vld;
	assign dec_drop_o = r.dec_drop;
	assign fwd_o = r.fwd;
	assign wr_word_vld_o = r.wvld;
	assign wr_word_o = r.wword;
	assign pause_o = r.fc_on;
	assign pfc_o = r.pfc_on;

	// ==========================================================
	// next state: usage, pause, admission, registers
	always_comb begin
		n = r;
		n.dec_vld = 1'b0;
		n.wvld = wr_gnt_o;
		n.wword = wr_gnt_o ? mm_word : r.wword;
		n.rdata = '0;
		// usage counters move with the grant and the release
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (wr_gnt_o && wr_i.port == p)
				n.puse[p] = n.puse[p] + 1'b1;
			if (rel_vld_i && rel_i.port == p)
				n.puse[p] = n.puse[p] - 1'b1;
			for (int q = 0; q < 8; q++) begin
				if (wr_gnt_o && wr_i.port == p && wr_i.prio == q)
					n.quse[p][q] = n.quse[p][q] + 1'b1;
				if (rel_vld_i && rel_i.port == p && rel_i.prio == q)
					n.quse[p][q] = n.quse[p][q] - 1'b1;
				if (r.drop_md[p] || !r.pfc_en[p][q])
					n.pfc_on[p][q] = 1'b0;
				else if (r.quse[p][q] >= r.p_start[p] && tot_fc)
					n.pfc_on[p][q] = 1'b1;
				else if (r.quse[p][q] < r.p_stop[p])
					n.pfc_on[p][q] = 1'b0;
			end
			if (r.drop_md[p] || !r.fc_en[p])
				n.fc_on[p] = 1'b0;
			else if (r.puse[p] >= r.p_start[p] && tot_fc)
				n.fc_on[p] = 1'b1;
			else if (r.puse[p] < r.p_stop[p])
				n.fc_on[p] = 1'b0;
		end
		// whole-frame decision at frame start
		if (frm_vld_i && fp_ok) begin
			n.discard[frm_i.port] = tail_hit || early_hit;
			n.dec_vld = 1'b1;
			n.dec_drop = tail_hit || early_hit;
			n.fwd = frm_i;
			if (!(tail_hit || early_hit) &&
				r.oam_mask[frm_i.res.oam_type])
				n.oam_cnt = r.oam_cnt + 1'b1;
		end
		// register writes; unmapped addresses are ignored
		if (reg_we_i && !reg_addr_i[sbac_pkg::GLB_BIT]) begin
			if (rp < NUM_PORTS) begin
				unique case (reg_addr_i[1:0])
					sbac_pkg::SUB_TAIL: n.tail_lim[rp] = reg_wdata_i[CW-1:0];
					sbac_pkg::SUB_PAUSE: begin
						n.p_start[rp] = reg_wdata_i[sbac_pkg::PS_START_LSB +: CW];
						n.p_stop[rp] = reg_wdata_i[sbac_pkg::PS_STOP_LSB +: CW];
					end
					sbac_pkg::SUB_SWITCH: begin
						n.drop_md[rp] = reg_wdata_i[sbac_pkg::SW_DROP_BIT];
						n.fc_en[rp] = reg_wdata_i[sbac_pkg::SW_FC_BIT];
						// drop mode silences pause in the same edge
						if (reg_wdata_i[sbac_pkg::SW_DROP_BIT]) begin
							n.fc_on[rp] = 1'b0;
							n.pfc_on[rp] = '0;
						end
					end
					sbac_pkg::SUB_PFC: n.pfc_en[rp] = reg_wdata_i[7:0];
				endcase
			end
		end else if (reg_we_i) begin
			if (reg_addr_i == sbac_pkg::A_TOT_TAIL)
				n.tot_tail = reg_wdata_i[CW-1:0];
			if (reg_addr_i == sbac_pkg::A_TOT_PAUSE)
				n.tot_pause = reg_wdata_i[CW-1:0];
			if (reg_addr_i == sbac_pkg::A_VIEW_SEL)
				n.view_sel = reg_wdata_i[PW-1:0];
			if (reg_addr_i == sbac_pkg::A_OAM_MASK)
				n.oam_mask = reg_wdata_i[7:0];
			// a frame counted in the clearing cycle is kept, not lost
			if (reg_addr_i == sbac_pkg::A_OAM_CNT)
				n.oam_cnt = 32'(n.oam_cnt != r.oam_cnt);
		end
		// register reads, answered in the next cycle
		if (reg_re_i && !reg_addr_i[sbac_pkg::GLB_BIT]) begin
			if (rp < NUM_PORTS) begin
				unique case (reg_addr_i[1:0])
					sbac_pkg::SUB_TAIL: n.rdata = 32'(r.tail_lim[rp]);
					sbac_pkg::SUB_PAUSE: begin
						n.rdata[sbac_pkg::PS_START_LSB +: CW] = r.p_start[rp];
						n.rdata[sbac_pkg::PS_STOP_LSB +: CW] = r.p_stop[rp];
					end
					sbac_pkg::SUB_SWITCH: begin
						n.rdata[sbac_pkg::SW_DROP_BIT] = r.drop_md[rp];
						n.rdata[sbac_pkg::SW_FC_BIT] = r.fc_en[rp];
					end
					sbac_pkg::SUB_PFC: n.rdata = 32'(r.pfc_en[rp]);
				endcase
			end
		end else if (reg_re_i) begin
			if (reg_addr_i == sbac_pkg::A_TOT_TAIL)
				n.rdata = 32'(r.tot_tail);
			if (reg_addr_i == sbac_pkg::A_TOT_PAUSE)
				n.rdata = 32'(r.tot_pause);
			if (reg_addr_i == sbac_pkg::A_VIEW_SEL)
				n.rdata = 32'(r.view_sel);
			if (reg_addr_i == sbac_pkg::A_PORT_USE &&
				r.view_sel < NUM_PORTS)
				n.rdata = 32'(r.puse[r.view_sel]);
			if (reg_addr_i == sbac_pkg::A_FREE_CNT)
				n.rdata = 32'(free_cnt);
			if (reg_addr_i == sbac_pkg::A_OAM_MASK)
				n.rdata = 32'(r.oam_mask);
			if (reg_addr_i == sbac_pkg::A_OAM_CNT)
				n.rdata = r.oam_cnt;
			if (reg_addr_i[10:3] == sbac_pkg::A_PRIO_BASE[10:3] &&
				r.view_sel < NUM_PORTS)
				n.rdata = 32'(r.quse[r.view_sel][reg_addr_i[2:0]]);
		end
	end

	// limits reset to maximum, stop levels to zero, so nothing trips before software acts
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
			r.tail_lim <= {NUM_PORTS{sbac_pkg::RST_LIM}};
			r.p_start <= {NUM_PORTS{sbac_pkg::RST_LIM}};
			r.p_stop <= {NUM_PORTS{sbac_pkg::RST_STOP}};
			r.tot_tail <= sbac_pkg::RST_LIM;
			r.tot_pause <= sbac_pkg::RST_LIM;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_gnt_needs_free: assert property (wr_gnt_o |-> free_cnt != '0)
		else $error("grant with no free word");
	a_free_falls: assert property (wr_gnt_o && !rel_vld_i |=>
		free_cnt == $past(free_cnt) - 1'b1)
		else $error("free count did not fall on grant");
	a_usage_rises: assert property (wr_gnt_o && !rel_vld_i |=>
		r.puse[$past(wr_i.port)] == $past(r.puse[wr_i.port]) + 1'b1)
		else $error("port usage did not rise on grant");
	a_tail_drops: assert property (frm_vld_i && tail_hit |=>
		dec_vld_o && dec_drop_o)
		else $error("frame over both limits was admitted");
	a_below_admits: assert property (frm_vld_i && fp_ok &&
		!drop_frame && used <= r.tot_tail |=> !dec_drop_o)
		else $error("frame below total limit was dropped");
	a_discard_whole: assert property (wr_req_i &&
		r.discard[wr_i.port] |-> !wr_gnt_o)
		else $error("word granted to a discarded frame");
	a_drop_no_pause: assert property ((pause_o & r.drop_md) == '0)
		else $error("pause on a drop-mode port");
	// every port is watched, not only the ones a test happens to pause
	for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_pchk
		a_pause_needs_tot: assert property ($rose(pause_o[gp]) |->
			$past(tot_fc))
			else $error("pause raised below total limit");
	end
	a_view_read: assert property (reg_re_i &&
		reg_addr_i == sbac_pkg::A_PORT_USE && r.view_sel < NUM_PORTS |=>
		reg_rdata_o == 32'($past(r.puse[r.view_sel])))
		else $error("port usage view mismatch");
	a_free_read: assert property (reg_re_i &&
		reg_addr_i == sbac_pkg::A_FREE_CNT |=>
		reg_rdata_o == 32'($past(free_cnt)))
		else $error("free word view mismatch");

	c_tail_drop: cover property (frm_vld_i ##1 dec_drop_o);
	c_pause_on: cover property ($rose(pause_o[0]) ##[1:200] $fell(pause_o[0]));
	c_pfc_on: cover property ($rose(pfc_o[0][0]));
	c_swap: cover property (wr_gnt_o && rel_vld_i);
endmodule // sbac_top

//--- sbac_top_test.sv
// sbac_top_test: register and traffic checks of admission control
module sbac_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int NW = 64;
	logic core_clk_i, rstn_i, we, re, frm_vld, dec_vld, dec_drop;
	logic [10:0] addr;
	logic [31:0] wdata, rdata;
	sbac_pkg::sbac_frame_t frm, fwd;
	sbac_pkg::sbac_word_req_t wr, rel;
	logic wr_req, gnt, wvld, rel_vld, ok;
	logic [14:0] word, rel_word, w;
	logic [69:0] pause;
	logic [69:0][7:0] pfc;
	int err_count, n_tests, cyc;
	// ==========================================================
	// design and partner
	sbac_top #(.NUM_WORDS(NW)) uut (.core_clk_i(core_clk_i),
		.rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
		.frm_vld_i(frm_vld), .frm_i(frm), .dec_vld_o(dec_vld),
		.dec_drop_o(dec_drop), .fwd_o(fwd), .wr_req_i(wr_req),
		.wr_i(wr), .wr_gnt_o(gnt), .wr_word_vld_o(wvld),
		.wr_word_o(word), .rel_vld_i(rel_vld), .rel_i(rel),
		.rel_word_i(rel_word), .pause_o(pause), .pfc_o(pfc));
	sbac_analyzer_model u_part (.core_clk_i(core_clk_i),
		.wr_gnt_i(gnt), .wr_word_i(word), .frm_vld_o(frm_vld),
		.frm_o(frm), .wr_req_o(wr_req), .wr_o(wr),
		.rel_vld_o(rel_vld), .rel_o(rel), .rel_word_o(rel_word));
	// ==========================================================
	// clock and hang guard; the run needs well under 3000 cycles
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	// ==========================================================
	// compares and bus tasks
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkf(input sbac_pkg::sbac_frame_t e);
		n_tests++;
		if (fwd !== e) begin
			err_count++;
			$display("ERROR fwd expected %h seen %h", e, fwd);
		end
	endtask
	task automatic wr_reg(input logic [10:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk_i);
		we <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input string n, input logic [10:0] a,
		input logic [31:0] e);
		@(posedge core_clk_i);
		re <= 1'b1;
		addr <= a;
		@(posedge core_clk_i);
		re <= 1'b0;
		#1;
		chk(n, e, rdata);
	endtask
	task automatic take(input logic [6:0] p, input logic [2:0] pr,
		input int n);
		repeat (n) begin
			u_part.alloc(p, pr, ok, w);
			chk("grant", 1, ok);
			chk("word valid", 1, wvld);
			chk("word range", 1, w < NW);
		end
	endtask
	// decision one cycle after the frame start
	task automatic frame(input logic [6:0] p, input logic dm,
		input logic [2:0] oam, input logic e);
		sbac_pkg::sbac_frame_t f;
		f = u_part.mk(p, dm, oam);
		u_part.send(f);
		#1;
		chk("dec valid", 1, dec_vld);
		chk("drop", e, dec_drop);
		if (!e) chkf(f);
	endtask
	task automatic settle();
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{rstn_i, we, re, addr, wdata} = '0;
		repeat (4) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		// the word stack refills one word a cycle after reset
		repeat (NW + 2) @(posedge core_clk_i);
		rd("free", sbac_pkg::A_FREE_CNT, NW);
		rd("tail lim", 11'h000, 32'h7FFF);
		rd("pause cfg", 11'h001, 32'h7FFF);
		rd("tot tail", sbac_pkg::A_TOT_TAIL, 32'h7FFF);
		rd("unmapped", 11'h118, 32'h0);
		take(7'h03, 3'h2, 5);
		rd("free", sbac_pkg::A_FREE_CNT, NW - 5);
		wr_reg(sbac_pkg::A_VIEW_SEL, 32'h3);
		rd("port use", sbac_pkg::A_PORT_USE, 32'h5);
		rd("prio use", sbac_pkg::A_PRIO_BASE + 11'h2, 32'h5);
		u_part.put_back();
		rd("free", sbac_pkg::A_FREE_CNT, NW - 4);
		rd("port use", sbac_pkg::A_PORT_USE, 32'h4);
		// port over its limit, total under: admitted
		wr_reg(11'h00C, 32'h2);
		wr_reg(sbac_pkg::A_TOT_TAIL, 32'hA);
		frame(7'h03, 1'b0, 3'h0, 1'b0);
		wr_reg(sbac_pkg::A_TOT_TAIL, 32'h3);
		frame(7'h03, 1'b0, 3'h0, 1'b1);
		u_part.alloc(7'h03, 3'h2, ok, w);
		chk("refused", 0, ok);
		wr_reg(sbac_pkg::A_TOT_TAIL, 32'h7FFF);
		frame(7'h03, 1'b0, 3'h0, 1'b0);
		repeat (4) u_part.put_back();
		// link and priority pause on port 5, start 2 stop 1
		wr_reg(11'h015, 32'h0001_0002);
		wr_reg(11'h016, 32'h2);
		wr_reg(11'h017, 32'h10);
		wr_reg(sbac_pkg::A_TOT_PAUSE, 32'h1);
		take(7'h05, 3'h4, 1);
		settle();
		chk("pause5 low", 0, pause[5]);
		take(7'h05, 3'h4, 1);
		settle();
		chk("pause5", 1, pause[5]);
		chk("pfc5", 32'h10, pfc[5]);
		frame(7'h05, 1'b1, 3'h0, 1'b1);
		frame(7'h05, 1'b0, 3'h0, 1'b0);
		u_part.put_back();
		settle();
		chk("pause5 held", 1, pause[5]);
		u_part.put_back();
		settle();
		chk("pause5 off", 0, pause[5]);
		chk("pfc5 off", 0, pfc[5]);
		// drop-mode port never signals congestion
		wr_reg(11'h019, 32'h0001_0001);
		wr_reg(11'h01A, 32'h3);
		take(7'h06, 3'h0, 1);
		settle();
		chk("pause6", 0, pause[6]);
		frame(7'h06, 1'b0, 3'h0, 1'b1);
		u_part.put_back();
		// only selected service frame types are counted
		wr_reg(sbac_pkg::A_OAM_MASK, 32'h2);
		frame(7'h00, 1'b0, 3'h1, 1'b0);
		frame(7'h00, 1'b0, 3'h2, 1'b0);
		rd("oam count", sbac_pkg::A_OAM_CNT, 32'h1);
		rd("free", sbac_pkg::A_FREE_CNT, NW);
		end_of_test();
	end
endmodule // sbac_top_test
